// File: inc/hga_consts.svh
// timing, address and width constants for the host bus grant port
`ifndef HGA_CONSTS_SVH
`define HGA_CONSTS_SVH
// ***************************************************
// clock and widths
// ***************************************************
`define HGA_CLK_PERIOD_PS 100000
`define HGA_ADDR_W 24
`define HGA_DATA_W 32
`define HGA_REG_DEPTH 16
// upper address line that marks a non-multiprocessor-space address
`define HGA_NONMMS_BIT 23
// ***************************************************
// times in ps, as printed
// ***************************************************
`define HGA_READ_LOW_MIN_PS 28000
`define HGA_WRITE_LOW_MIN_PS 7750
`define HGA_DATA_LEAD_MIN_PS 1500
// least times round up to whole cycles
`define HGA_CYC_UP(ps) (((ps) + `HGA_CLK_PERIOD_PS - 1) / `HGA_CLK_PERIOD_PS)
`define HGA_READ_LOW_CYC `HGA_CYC_UP(`HGA_READ_LOW_MIN_PS)
`define HGA_WRITE_LOW_CYC `HGA_CYC_UP(`HGA_WRITE_LOW_MIN_PS)
`define HGA_DATA_LEAD_CYC `HGA_CYC_UP(`HGA_DATA_LEAD_MIN_PS)
`endif

// File: inc/hga_pkg.sv
// state types for both ends of the host bus grant port
`default_nettype none
package hga_pkg;
    // ***************************************************
    // device end access sequence
    // ***************************************************
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_WAIT,
        DEV_ACCESS,
        DEV_DONE
    } hga_dev_state_type;
    // ***************************************************
    // host end access sequence
    // ***************************************************
    typedef enum logic [1:0] {
        HST_IDLE,
        HST_REQUEST,
        HST_STROBE,
        HST_HOLD
    } hga_host_state_type;
endpackage : hga_pkg
`default_nettype wire

// File: inc/hga_bus_if.sv
// pins between the host processor and the device, with wire resolution
`default_nettype none
interface hga_bus_if #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 32
);
    // host driven
    logic host_bus_request_n;
    logic chip_select_n;
    logic read_n;
    logic write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_wdata;
    logic host_wdata_oe;
    // device driven
    logic host_bus_grant_n;
    logic [DATA_W-1:0] dev_rdata;
    logic dev_rdata_oe;
    logic host_access_ready_o;
    logic host_access_ready_oe;
    logic peer_bus_request_n_o;
    logic core_priority_access_n_o;
    logic core_priority_access_n_oe;
    // driven by peers, from the bench
    logic peer_bus_request_n;
    logic core_priority_access_n_ext;
    // resolved wires, pull-ups on ready and priority where nobody drives, data reads zero
    logic host_access_ready;
    logic core_priority_access_n;
    logic [DATA_W-1:0] data;
    assign host_access_ready = host_access_ready_oe ? host_access_ready_o : 1'b1;
    assign core_priority_access_n = (core_priority_access_n_oe ? core_priority_access_n_o : 1'b1)
        & core_priority_access_n_ext;
    assign data = dev_rdata_oe ? dev_rdata : (host_wdata_oe ? host_wdata : '0);
    modport device (
        input host_bus_request_n, chip_select_n, read_n, write_n, addr, data,
        input peer_bus_request_n, core_priority_access_n,
        output host_bus_grant_n, dev_rdata, dev_rdata_oe, host_access_ready_o, host_access_ready_oe,
        output peer_bus_request_n_o, core_priority_access_n_o, core_priority_access_n_oe
    );
    modport host (
        output host_bus_request_n, chip_select_n, read_n, write_n, addr, host_wdata, host_wdata_oe,
        input host_bus_grant_n, host_access_ready, data
    );
endinterface : hga_bus_if
`default_nettype wire

// File: hdl/hga_device.sv
// device end: host bus grant, ready pacing and host access to io_processor_regs
// Function
// [R1] grant after select and request, then strobes
// [R2] first access address outside multiproc space
// [R3] host drives upper address high while granted; host end drops it with the request, a cycle before grant ends
// [R4] host request sampled on each clock
// [R5] priority assert clocked, deassert taken at once
// [R6] ready low at once on select and request
// [R7] grant ends ready low: release or high
// [R8] active drive stops when select/request rise
// [R9] read: ready low, data valid before release
// [R10] host holds strobe until ready released
// [R11] ready low minimum: longer read, shorter write
// [R12] writes spaced at least half a period
// [R13] data bus released when read strobe rises
// [R14] priority driven low by clock, then floated
// [R15] grant held while request low, then withdrawn
`include "hga_consts.svh"
`default_nettype none
module hga_device #(
    parameter int ADDR_W = `HGA_ADDR_W,
    parameter int DATA_W = `HGA_DATA_W,
    parameter int DEPTH = `HGA_REG_DEPTH
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // pins toward the host and the peers
    hga_bus_if.device BUS,
    // configuration and core requests
    input wire logic ACTIVE_DRIVE_I,
    input wire logic CORE_BUS_REQ_I,
    input wire logic CORE_PRIORITY_I,
    // core view of the io_processor_regs
    input wire logic [$clog2(DEPTH)-1:0] REG_RADDR_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    // status
    output logic HOST_GRANTED_O,
    output logic PRIORITY_SEEN_O
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam logic [3:0] READ_LIMIT = 4'(`HGA_READ_LOW_CYC + `HGA_DATA_LEAD_CYC);
    localparam logic [3:0] WRITE_LIMIT = 4'(`HGA_WRITE_LOW_CYC);

    // whole control state of this end
    typedef struct packed {
        hga_pkg::hga_dev_state_type st;
        logic grant_n;             // host bus grant, registered
        logic [3:0] cnt;           // ready-low cycles so far
        logic is_read;             // current access is a read
        logic addr_ok;             // access may touch the registers
        logic first_done;          // first access of this tenure seen
        logic data_drive;          // read data owns the bus
        logic [DATA_W-1:0] rdata;  // read data, from flops
        logic cpa_seen;            // priority assertion, sampled
        logic cpa_drive;           // our own priority request
        logic peer_req_n;          // our own bus request
        logic [DATA_W-1:0] core_rd; // core read port
    } hga_dev_reg_type;

    hga_dev_reg_type r;
    hga_dev_reg_type next_r;
    logic [DATA_W-1:0] regs [DEPTH];  // io_processor_regs
    logic mem_we;                     // commit a host write this edge
    logic sel;                        // select and request both low
    logic strobe_low;                 // read or write strobe low
    logic cpa_active;                 // priority access in force
    logic ready_low;                  // ready pulled low this cycle
    logic [IDX_W-1:0] idx;            // register index from address

    // ***************************************************
    // combinational pin decode
    // ***************************************************
    assign sel = ~BUS.chip_select_n & ~BUS.host_bus_request_n;
    assign strobe_low = ~BUS.read_n | ~BUS.write_n;
    assign idx = BUS.addr[IDX_W-1:0];
    // assertion counts only once sampled, release counts at once
    assign cpa_active = r.cpa_seen & ~BUS.core_priority_access_n;  // R5

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        next_r = r;
        mem_we = 1'b0;
        next_r.cpa_seen = ~BUS.core_priority_access_n;  // R5
        next_r.cpa_drive = CORE_PRIORITY_I;  // R14
        next_r.peer_req_n = ~CORE_BUS_REQ_I;
        next_r.core_rd = regs[REG_RADDR_I];
        if (BUS.host_bus_request_n) begin
            // request gone: withdraw grant, forget the tenure
            next_r.grant_n = 1'b1;  // R15
            next_r.st = hga_pkg::DEV_IDLE;
            next_r.first_done = 1'b0;
            next_r.data_drive = 1'b0;
        end else begin
            unique case (r.st)
                hga_pkg::DEV_IDLE: begin
                    // request sampled on this edge, chip select needed too
                    if (sel && !cpa_active && !CORE_BUS_REQ_I) begin
                        next_r.grant_n = 1'b0;  // R1 R4
                        next_r.st = hga_pkg::DEV_WAIT;
                    end
                end
                hga_pkg::DEV_WAIT: begin
                    // granted, strobe starts an access
                    if (strobe_low && !BUS.chip_select_n) begin
                        next_r.st = hga_pkg::DEV_ACCESS;
                        next_r.cnt = 4'h1;
                        next_r.is_read = ~BUS.read_n;
                        // an early access into multiproc space is dropped
                        next_r.addr_ok = BUS.addr[`HGA_NONMMS_BIT] | r.first_done;  // R2 R3
                        next_r.first_done = 1'b1;
                        next_r.rdata = next_r.addr_ok ? regs[idx] : '0;
                        next_r.data_drive = ~BUS.read_n;  // R9
                    end
                end
                hga_pkg::DEV_ACCESS: begin
                    // hold ready low for the read or write minimum
                    if (r.cnt >= (r.is_read ? READ_LIMIT : WRITE_LIMIT)) begin  // R11
                        next_r.st = hga_pkg::DEV_DONE;
                        mem_we = ~r.is_read & r.addr_ok;
                    end else begin
                        next_r.cnt = r.cnt + 4'h1;
                    end
                end
                hga_pkg::DEV_DONE: begin
                    // host keeps strobe low until ready is back
                    if (!strobe_low) begin  // R10
                        next_r.st = hga_pkg::DEV_WAIT;
                        next_r.data_drive = 1'b0;
                    end
                end
            endcase
        end
    end

    // ***************************************************
    // state register, synchronous reset
    // ***************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            r <= '{st: hga_pkg::DEV_IDLE, grant_n: 1'b1, cnt: 4'h0, is_read: 1'b0, addr_ok: 1'b0,
                   first_done: 1'b0, data_drive: 1'b0, rdata: '0, cpa_seen: 1'b0,
                   cpa_drive: 1'b0, peer_req_n: 1'b1, core_rd: '0};
        end else begin
            r <= next_r;
        end
    end

    // ***************************************************
    // register array; writes land after the write minimum
    // ***************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            for (int i = 0; i < DEPTH; i++) begin
                regs[i] <= '0;
            end
        end else if (mem_we) begin
            // data is stable: host holds the strobe low until release
            regs[idx] <= BUS.data;  // R12
        end
    end

    // ***************************************************
    // ready line: combinational so it reacts inside a cycle
    // ***************************************************
    always_comb begin
        // before grant: low at once; grant lifts it
        ready_low = sel & r.grant_n;  // R6 R7
        // during an access: low from strobe fall to the minimum's end
        if (sel && !r.grant_n && strobe_low &&
            (r.st == hga_pkg::DEV_WAIT || r.st == hga_pkg::DEV_ACCESS)) begin
            ready_low = 1'b1;  // R9
        end
    end
    // open drain drives only the low; active drive owns the line while selected
    assign BUS.host_access_ready_oe = ACTIVE_DRIVE_I ? sel : ready_low;  // R7 R8
    assign BUS.host_access_ready_o = ACTIVE_DRIVE_I ? ~ready_low : 1'b0;  // R7

    // ***************************************************
    // remaining pins and status
    // ***************************************************
    assign BUS.host_bus_grant_n = r.grant_n;  // R1
    assign BUS.dev_rdata = r.rdata;
    // drops in the same cycle the read strobe rises
    assign BUS.dev_rdata_oe = r.data_drive & ~BUS.read_n;  // R13
    assign BUS.core_priority_access_n_o = 1'b0;
    assign BUS.core_priority_access_n_oe = r.cpa_drive;  // R14
    assign BUS.peer_bus_request_n_o = r.peer_req_n;
    assign REG_RDATA_O = r.core_rd;
    assign HOST_GRANTED_O = ~r.grant_n;
    assign PRIORITY_SEEN_O = cpa_active;
endmodule : hga_device
`default_nettype wire

// File: hdl/hga_host.sv
// host end: requests the bus and performs paced register reads and writes
`include "hga_consts.svh"
`default_nettype none
module hga_host #(
    parameter int ADDR_W = `HGA_ADDR_W,
    parameter int DATA_W = `HGA_DATA_W
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // pins toward the device
    hga_bus_if.host BUS,
    // command from the host user
    input wire logic CMD_VALID_I,
    input wire logic CMD_WRITE_I,
    input wire logic [ADDR_W-2:0] CMD_ADDR_I,
    input wire logic [DATA_W-1:0] CMD_WDATA_I,
    output logic CMD_READY_O,
    // read answer
    output logic RSP_VALID_O,
    output logic [DATA_W-1:0] RSP_DATA_O
);
    // whole control state of this end
    typedef struct packed {
        hga_pkg::hga_host_state_type st;
        logic req_n;               // bus request and chip select
        logic rd_n;
        logic wr_n;
        logic is_write;
        logic [ADDR_W-2:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wdata_oe;
        logic seen_low;            // ready went low in this access
        logic rsp_valid;
        logic [DATA_W-1:0] rsp_data;
    } hga_host_reg_type;

    hga_host_reg_type r;
    hga_host_reg_type next_r;

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        unique case (r.st)
            hga_pkg::HST_IDLE: begin
                // latch a command and raise the request with select
                if (CMD_VALID_I) begin
                    next_r.req_n = 1'b0;
                    next_r.is_write = CMD_WRITE_I;
                    next_r.addr = CMD_ADDR_I;
                    next_r.wdata = CMD_WDATA_I;
                    next_r.st = hga_pkg::HST_REQUEST;
                end
            end
            hga_pkg::HST_REQUEST: begin
                // strobes only once the grant is seen
                if (!BUS.host_bus_grant_n) begin  // R1
                    next_r.rd_n = r.is_write;
                    next_r.wr_n = ~r.is_write;
                    next_r.wdata_oe = r.is_write;
                    next_r.seen_low = 1'b0;
                    next_r.st = hga_pkg::HST_STROBE;
                end
            end
            hga_pkg::HST_STROBE: begin
                // hold strobe until ready has dipped and come back
                if (!BUS.host_access_ready) begin
                    next_r.seen_low = 1'b1;
                end else if (r.seen_low) begin  // R10
                    next_r.rd_n = 1'b1;
                    next_r.wr_n = 1'b1;
                    next_r.rsp_valid = ~r.is_write;
                    next_r.rsp_data = BUS.data;
                    next_r.st = hga_pkg::HST_HOLD;
                end
            end
            hga_pkg::HST_HOLD: begin
                // strobe high a full cycle: write data held past the rise
                next_r.wdata_oe = 1'b0;
                if (CMD_VALID_I && !BUS.host_bus_grant_n) begin  // R12
                    next_r.is_write = CMD_WRITE_I;
                    next_r.addr = CMD_ADDR_I;
                    next_r.wdata = CMD_WDATA_I;
                    next_r.rd_n = CMD_WRITE_I;
                    next_r.wr_n = ~CMD_WRITE_I;
                    next_r.wdata_oe = CMD_WRITE_I;
                    next_r.seen_low = 1'b0;
                    next_r.st = hga_pkg::HST_STROBE;
                end else begin
                    next_r.req_n = 1'b1;
                    next_r.st = hga_pkg::HST_IDLE;
                end
            end
        endcase
    end

    // ***************************************************
    // state register, synchronous reset
    // ***************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            r <= '{st: hga_pkg::HST_IDLE, req_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, is_write: 1'b0,
                   addr: '0, wdata: '0, wdata_oe: 1'b0, seen_low: 1'b0, rsp_valid: 1'b0,
                   rsp_data: '0};
        end else begin
            r <= next_r;
        end
    end

    // ***************************************************
    // pins: upper address line high whenever requesting
    // ***************************************************
    assign BUS.host_bus_request_n = r.req_n;
    assign BUS.chip_select_n = r.req_n;
    assign BUS.read_n = r.rd_n;
    assign BUS.write_n = r.wr_n;
    assign BUS.addr = {~r.req_n, r.addr};  // R2 R3
    assign BUS.host_wdata = r.wdata;
    assign BUS.host_wdata_oe = r.wdata_oe;
    assign CMD_READY_O = (r.st == hga_pkg::HST_IDLE) || (r.st == hga_pkg::HST_HOLD && !BUS.host_bus_grant_n);
    assign RSP_VALID_O = r.rsp_valid;
    assign RSP_DATA_O = r.rsp_data;
endmodule : hga_host
`default_nettype wire

// File: testbench/hga_bus_monitor.sv
// concurrent checks on the pins between host end and device end
`include "hga_consts.svh"
`default_nettype none
module hga_bus_monitor (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // host driven pins
    input wire logic host_bus_request_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [`HGA_ADDR_W-1:0] addr,
    // device driven and resolved pins
    input wire logic host_bus_grant_n,
    input wire logic dev_rdata_oe,
    input wire logic host_access_ready_oe,
    input wire logic host_access_ready,
    input wire logic core_priority_access_n_o,
    input wire logic core_priority_access_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************
    // clocking and access sequences
    // ***************************************************
    default clocking mon_cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // read pacing covers fetch plus data lead, release bounded
    sequence read_pace_seq;
        !host_access_ready [*3] ##[1:4] host_access_ready;
    endsequence
    // write pacing is shorter
    sequence write_pace_seq;
        !host_access_ready [*2] ##[1:4] host_access_ready;
    endsequence
    // ***************************************************
    // assertions
    // ***************************************************
    a_grant_after_req: assert property ($fell(host_bus_grant_n)
        |-> !$past(host_bus_request_n) && !$past(chip_select_n))
        else $error("grant without request and select");
    a_strobe_needs_grant: assert property (($fell(read_n) || $fell(write_n)) |-> !host_bus_grant_n)
        else $error("strobe before grant");
    a_nonmms_address: assert property (!host_bus_request_n |-> addr[`HGA_NONMMS_BIT])
        else $error("upper address low while requesting");
    a_ready_low_select: assert property ((!chip_select_n && !host_bus_request_n && host_bus_grant_n)
        |-> !host_access_ready)
        else $error("ready not low before grant");
    a_grant_ends_ready: assert property ($fell(host_bus_grant_n) |-> host_access_ready)
        else $error("ready still low at grant");
    a_drive_stops_deselect: assert property ((chip_select_n || host_bus_request_n) |-> !host_access_ready_oe)
        else $error("ready driven while deselected");
    a_read_ready_pace: assert property ($fell(read_n) |-> read_pace_seq)
        else $error("read ready pulse wrong");
    a_write_ready_pace: assert property ($fell(write_n) |-> write_pace_seq)
        else $error("write ready pulse wrong");
    a_data_before_release: assert property (($rose(host_access_ready) && !read_n) |-> $past(dev_rdata_oe))
        else $error("read data not valid before ready release");
    a_data_bus_release: assert property ($rose(read_n) |-> !dev_rdata_oe)
        else $error("data still driven after read strobe");
    a_grant_follows_req: assert property (!host_bus_grant_n |=> host_bus_grant_n == $past(host_bus_request_n))
        else $error("grant not held or not withdrawn");
    a_priority_low_only: assert property (core_priority_access_n_oe |-> !core_priority_access_n_o)
        else $error("priority line driven high");
endmodule : hga_bus_monitor
`default_nettype wire

// File: testbench/test_host_bus_grant_and_async_access.sv
// self-checking bench joining host end and device end of the grant port
`include "hga_consts.svh"
`default_nettype none
module test_host_bus_grant_and_async_access;
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************
    // signals, model and counters
    // ***************************************************
    localparam int DLY = 10; // drive delay after the rising edge
    localparam int LIMIT = 20000; // cycle ceiling, run needs far fewer
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic active_drive = 1'b0;
    logic core_bus_req = 1'b0;
    logic core_priority = 1'b0;
    logic [3:0] reg_raddr = 4'h0;
    logic [`HGA_DATA_W-1:0] reg_rdata;
    logic host_granted;
    logic priority_seen;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [`HGA_ADDR_W-2:0] cmd_addr = '0;
    logic [`HGA_DATA_W-1:0] cmd_wdata = '0;
    logic cmd_ready;
    logic rsp_valid;
    logic [`HGA_DATA_W-1:0] rsp_data;
    logic [`HGA_DATA_W-1:0] model [16]; // expected register contents
    logic [`HGA_DATA_W-1:0] exp_q [$]; // reads in flight, in order
    integer seed = 32'h6073530f;
    integer n_fail = 0;
    integer tests_run = 0;
    integer cycles = 0;
    // ***************************************************
    // both ends across one interface
    // ***************************************************
    hga_bus_if #(.ADDR_W(`HGA_ADDR_W), .DATA_W(`HGA_DATA_W)) bus ();
    hga_device #(.ADDR_W(`HGA_ADDR_W), .DATA_W(`HGA_DATA_W), .DEPTH(`HGA_REG_DEPTH)) hga_device_i (
        .CORE_CLK_I(core_clk), .RESET_I(reset), .BUS(bus), .ACTIVE_DRIVE_I(active_drive),
        .CORE_BUS_REQ_I(core_bus_req), .CORE_PRIORITY_I(core_priority), .REG_RADDR_I(reg_raddr),
        .REG_RDATA_O(reg_rdata), .HOST_GRANTED_O(host_granted), .PRIORITY_SEEN_O(priority_seen));
    hga_host #(.ADDR_W(`HGA_ADDR_W), .DATA_W(`HGA_DATA_W)) hga_host_i (
        .CORE_CLK_I(core_clk), .RESET_I(reset), .BUS(bus), .CMD_VALID_I(cmd_valid),
        .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_WDATA_I(cmd_wdata),
        .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data));
    hga_bus_monitor hga_bus_monitor_i (
        .CORE_CLK_I(core_clk), .RESET_I(reset), .host_bus_request_n(bus.host_bus_request_n),
        .chip_select_n(bus.chip_select_n), .read_n(bus.read_n), .write_n(bus.write_n), .addr(bus.addr),
        .host_bus_grant_n(bus.host_bus_grant_n), .dev_rdata_oe(bus.dev_rdata_oe),
        .host_access_ready_oe(bus.host_access_ready_oe), .host_access_ready(bus.host_access_ready),
        .core_priority_access_n_o(bus.core_priority_access_n_o),
        .core_priority_access_n_oe(bus.core_priority_access_n_oe));
    // ***************************************************
    // clock, timeout and shared tasks
    // ***************************************************
    always #50 core_clk = ~core_clk;
    // hang guard counts as a mismatch
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            $display("BAD %0t run timed out", $time);
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic ok, input string msg);
        tests_run = tests_run + 1;
        if (ok !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    // read answers compared with the model in order
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) check(1'b0, "unexpected read answer");
            else check(rsp_data === exp_q.pop_front(), "read data differs");
        end
    end
    // one host command, handed over at the edge where ready is high
    task automatic cmd(input logic wr, input logic [3:0] idx);
        integer n;
        logic [31:0] r;
        n = 0;
        r = $random(seed);
        @(posedge core_clk);
        #DLY;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = r[`HGA_ADDR_W-2:0];
        cmd_addr[3:0] = idx;
        cmd_wdata = $random(seed);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #DLY;
            n = n + 1;
        end
        check(n < 200, "command not taken");
        @(posedge core_clk);
        if (wr) model[idx] = cmd_wdata;
        else exp_q.push_back(model[idx]);
        #DLY;
        cmd_valid = 1'b0;
    endtask : cmd
    // wait until answers are in and the bus is handed back
    task automatic drain();
        integer n;
        n = 0;
        while ((exp_q.size() != 0 || bus.host_bus_request_n !== 1'b1 || bus.host_bus_grant_n !== 1'b1)
               && n < 200) begin
            @(posedge core_clk);
            #DLY;
            n = n + 1;
        end
        check(n < 200, "access did not complete");
    endtask : drain
    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        logic [31:0] r;
        bus.peer_bus_request_n = 1'b1;
        bus.core_priority_access_n_ext = 1'b1;
        // both ready modes, mode held static under reset
        for (int m = 0; m < 2; m++) begin
            active_drive = m[0];
            reset = 1'b1;
            repeat (5) @(posedge core_clk);
            #DLY;
            reset = 1'b0;
            for (int i = 0; i < 16; i++) cmd(1'b1, i[3:0]);
            for (int i = 0; i < 32; i++) begin
                r = $random(seed);
                cmd(r[4], r[3:0]);
            end
            drain();
            check(host_granted === 1'b0, "still granted when idle");
            for (int i = 0; i < 16; i++) begin
                reg_raddr = i[3:0];
                @(posedge core_clk);
                #DLY;
                check(reg_rdata === model[i], "core side read differs");
            end
            $display("test ready mode %0d done", m);
        end
        // core owning the bus holds back the grant, ready waits low
        @(posedge core_clk);
        #DLY;
        core_bus_req = 1'b1;
        repeat (2) @(posedge core_clk);
        #DLY;
        check(bus.peer_bus_request_n_o === 1'b0, "peer request not driven");
        cmd(1'b0, 4'h5);
        repeat (4) @(posedge core_clk);
        #DLY;
        check(bus.host_bus_grant_n === 1'b1 && bus.host_access_ready === 1'b0, "grant while core owns bus");
        core_bus_req = 1'b0;
        @(posedge core_clk);
        #DLY;
        check(bus.host_bus_grant_n === 1'b0, "request not taken at once");
        drain();
        $display("test core request done");
        // priority line from a peer, then driven by the device
        bus.core_priority_access_n_ext = 1'b0;
        @(posedge core_clk);
        #DLY;
        check(priority_seen === 1'b1, "priority assertion not seen");
        bus.core_priority_access_n_ext = 1'b1;
        #1;
        check(priority_seen === 1'b0, "priority release not immediate");
        @(posedge core_clk);
        #DLY;
        core_priority = 1'b1;
        repeat (2) @(posedge core_clk);
        #DLY;
        check(bus.core_priority_access_n === 1'b0, "priority not driven low");
        core_priority = 1'b0;
        repeat (2) @(posedge core_clk);
        #DLY;
        check(bus.core_priority_access_n === 1'b1 && bus.core_priority_access_n_oe === 1'b0,
              "priority not floated");
        $display("test priority done");
        close_out();
    end
endmodule : test_host_bus_grant_and_async_access
`default_nettype wire
